// file: sctc_touch_counter.v
/*
  Sequencer of the switched-capacitance touch-key converter: register file,
  zeroing, charge-and-dump loop, comparator filter, repeat accumulation and
  the done interrupt.
  Assumes the analog comparator output is asynchronous to sys_clk and that
  the switch controls are sampled by the analog front end directly.
*/
// Operation
// RL1: Software start command begins every conversion; here only the first of a repeat sequence.
// RL2: Short integration capacitor, then release before transfer.
// RL3: Charge, dump, and count every cycle.
// RL4: Filtered threshold ends detection, stores count.
// RL5: Completion raises the shared touch interrupt.
// RL6: Threshold bit picks three-quarter or half.
// RL7: Each phase lasts base time plus one; zeroing here lasts zero_len plus one instead.
// RL8: Filter needs last N samples all ones.
// RL9: Reference bit picks core or main supply.
// RL10: Repeat field accumulates 1, 2, 4, 8 conversions.
// RL11: Done flag stays set until software clears.
// RL12: Start command clears the accumulated count.
// RL13: Count registers hold total after completion.
// RL14: Converter timed from the system oscillator clock.
// RL15: Command bit zero reads busy during sequence.
// RL16: Request only when enable and flag set; masked status bits also raise it here.
// RL17: Count is 18 bits, MSBs in command.
`timescale 1ns/100ps
`include "sctc_regs.vh"

module sctc_touch_counter
(
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Analog front end.
  input wire comp_out,
  output reg zero_sw,
  output reg charge_sw,
  output reg dump_sw,
  output wire threshold_half,
  output wire reference_main,
  output wire converter_enable,
  output wire pad_drive_enable,
  // Interrupt.
  output wire irq
);

  // Sequencer states.
  localparam ST_IDLE = 3'd0;
  localparam ST_ZERO = 3'd1;
  localparam ST_CHARGE = 3'd2;
  localparam ST_DUMP = 3'd3;
  localparam ST_DONE = 3'd4;

  // Software-visible registers.
  reg [7:0] cfg_a_r; // Enable, random, reference, threshold, base time.
  reg [7:0] cfg_b_r; // Pad enable, zero length, filter length.
  reg done_irq_enable_r; // Done interrupt enable.
  reg auto_scale_shift_r; // Scale accumulated sum down by repeat count.
  reg [1:0] repeat_count_r; // Conversions per sequence, log2.
  reg done_flag_r; // Sticky completion flag.
  reg [17:0] cycle_count_r; // Published count.
  reg [1:0] irq_stat_r; // Sticky events: bit0 done, bit1 overflow.
  reg [1:0] irq_mask_r; // Mask of the same layout.

  // Sequencer state.
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [11:0] timer_r; // Phase timer.
  reg [17:0] accum_r; // Running accumulation of cycles.
  reg [3:0] conv_left_r; // Conversions still to run.
  reg ovf_r; // Accumulator saturated.

  // Comparator synchroniser and filter.
  reg [2:0] comp_sync_r;
  reg comp_stable_r;
  reg [3:0] filt_cnt_r;
  reg comp_filt_r;

  // Decoded strobes.
  wire wr_cfg_a = reg_wr && (reg_addr == `SCTC_OFS_CFG_A);
  wire wr_cfg_b = reg_wr && (reg_addr == `SCTC_OFS_CFG_B);
  wire wr_cmd = reg_wr && (reg_addr == `SCTC_OFS_CMD);
  wire wr_cnt_lo = reg_wr && (reg_addr == `SCTC_OFS_CNT_LO);
  wire wr_cnt_hi = reg_wr && (reg_addr == `SCTC_OFS_CNT_HI);
  wire wr_mask = reg_wr && (reg_addr == `SCTC_OFS_IRQ_MASK);
  wire rd_stat = reg_rd && (reg_addr == `SCTC_OFS_IRQ_STAT);
  wire busy = (state_r != ST_IDLE);
  // A start is taken only while enabled and idle; a start during busy is dropped.
  wire start_cmd = wr_cmd && reg_wdata[`SCTC_C_BUSY] && !busy && cfg_a_r[`SCTC_A_ENABLE]; // RL1
  wire [11:0] phase_len = {8'h00, cfg_a_r[3:0]}; // RL7
  wire [11:0] zero_len = `SCTC_ZERO_BASE + `SCTC_ZERO_STEP * {9'h000, cfg_b_r[6:4]}
    + `SCTC_ZERO_STEP + `SCTC_ZERO_TAIL;
  wire timer_end = (timer_r == 12'h000);
  wire conv_done = (state_r == ST_DUMP) && timer_end && comp_filt_r; // RL4
  wire seq_done = conv_done && (conv_left_r == 4'h1);
  wire [17:0] accum_inc = (accum_r == 18'h3ffff) ? accum_r : accum_r + 18'h00001;

  // Number of conversions for a repeat code.
  function [3:0] rep_total;
    input [1:0] code;
    begin
      rep_total = 4'h1 << code; // RL10
    end
  endfunction

  // Threshold and reference routing straight from configuration.
  assign threshold_half = cfg_a_r[`SCTC_A_THSEL]; // RL6
  assign reference_main = cfg_a_r[`SCTC_A_REFERENCE_SELECT]; // RL9
  assign converter_enable = cfg_a_r[`SCTC_A_ENABLE];
  assign pad_drive_enable = cfg_b_r[`SCTC_B_PADEN];
  // Request follows enable and flag; the extra sources join through the mask.
  assign irq = (done_irq_enable_r && done_flag_r) || |(irq_stat_r & irq_mask_r); // RL16

  // Comparator: three flops, a change counts when the last two agree.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      comp_sync_r <= 3'b000;
      comp_stable_r <= 1'b0;
    end
    else
    begin
      comp_sync_r <= {comp_sync_r[1:0], comp_out};
      if (comp_sync_r[1] == comp_sync_r[2])
      begin
        comp_stable_r <= comp_sync_r[2];
      end
    end
  end

  // Run-length filter: asserted once N consecutive samples were ones.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      filt_cnt_r <= 4'h0;
      comp_filt_r <= 1'b0;
    end
    else if (!comp_stable_r)
    begin
      filt_cnt_r <= 4'h0;
      comp_filt_r <= 1'b0;
    end
    else
    begin
      // Counter saturates so a long run keeps the output high.
      if (filt_cnt_r != 4'hf)
      begin
        filt_cnt_r <= filt_cnt_r + 4'h1;
      end
      comp_filt_r <= ({1'b0, filt_cnt_r} + 5'd1 >= {1'b0, cfg_b_r[3:0]}); // RL8
    end
  end

  // Sequencer next-state logic.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          state_nxt = ST_ZERO;
        end
      end
      ST_ZERO:
      begin
        if (timer_end)
        begin
          state_nxt = ST_CHARGE; // RL2
        end
      end
      ST_CHARGE:
      begin
        if (timer_end)
        begin
          state_nxt = ST_DUMP;
        end
      end
      ST_DUMP:
      begin
        if (timer_end)
        begin
          if (seq_done)
          begin
            state_nxt = ST_DONE;
          end
          else if (conv_done)
          begin
            state_nxt = ST_ZERO;
          end
          else
          begin
            state_nxt = ST_CHARGE; // RL3
          end
        end
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Disabling the converter aborts any sequence.
    if (!cfg_a_r[`SCTC_A_ENABLE])
    begin
      state_nxt = ST_IDLE;
    end
  end

  // Sequencer registers, switches and accumulator.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      timer_r <= 12'h000;
      accum_r <= 18'h00000;
      conv_left_r <= 4'h0;
      ovf_r <= 1'b0;
      zero_sw <= 1'b0;
      charge_sw <= 1'b0;
      dump_sw <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      // Timer reloads on every state entry, counting down to zero.
      if (state_nxt != state_r || (state_r == ST_DUMP && timer_end))
      begin
        timer_r <= (state_nxt == ST_ZERO) ? zero_len : phase_len; // RL7
      end
      else if (!timer_end)
      begin
        timer_r <= timer_r - 12'h001;
      end
      if (start_cmd)
      begin
        accum_r <= 18'h00000; // RL12
        // The repeat field is written together with the start bit, so take it from the bus.
        conv_left_r <= rep_total(reg_wdata[3:2]); // RL10
        ovf_r <= 1'b0;
      end
      else if (state_r == ST_DUMP && timer_end)
      begin
        accum_r <= accum_inc; // RL3
        if (accum_r == 18'h3ffff)
        begin
          ovf_r <= 1'b1;
        end
        if (conv_done)
        begin
          conv_left_r <= conv_left_r - 4'h1;
        end
      end
      // Switches are registered so they never glitch at the front end.
      zero_sw <= (state_nxt == ST_ZERO); // RL2
      charge_sw <= (state_nxt == ST_CHARGE); // RL3
      dump_sw <= (state_nxt == ST_DUMP);
    end
  end

  // Register writes, flags and published count.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_a_r <= `SCTC_RST_BYTE;
      cfg_b_r <= `SCTC_RST_BYTE;
      done_irq_enable_r <= 1'b0;
      auto_scale_shift_r <= 1'b0;
      repeat_count_r <= 2'b00;
      done_flag_r <= 1'b0;
      cycle_count_r <= 18'h00000;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
    end
    else
    begin
      if (wr_cfg_a)
      begin
        cfg_a_r <= reg_wdata;
      end
      if (wr_cfg_b)
      begin
        cfg_b_r <= reg_wdata;
      end
      if (wr_mask)
      begin
        irq_mask_r <= reg_wdata[1:0];
      end
      if (wr_cmd)
      begin
        done_irq_enable_r <= reg_wdata[`SCTC_C_IRQEN];
        auto_scale_shift_r <= reg_wdata[`SCTC_C_AUTO_SCALE_SHIFT];
        repeat_count_r <= reg_wdata[3:2];
      end
      // Writing zero clears the flag; completion in the same cycle wins.
      if (state_r == ST_DONE)
      begin
        done_flag_r <= 1'b1; // RL11
      end
      else if (wr_cmd && !reg_wdata[`SCTC_C_DONE])
      begin
        done_flag_r <= 1'b0; // RL11
      end
      // Read clears status; new events in that cycle survive.
      irq_stat_r <= (rd_stat ? 2'b00 : irq_stat_r)
        | {(state_r == ST_DONE) && ovf_r, state_r == ST_DONE}; // RL5
      // Publish at completion; software may also preload the low bytes.
      if (start_cmd)
      begin
        cycle_count_r <= 18'h00000; // RL12
      end
      else if (state_r == ST_DONE)
      begin
        // Optional scaling divides by the number of repeats taken.
        cycle_count_r <= auto_scale_shift_r ? (accum_r >> repeat_count_r) : accum_r; // RL13
      end
      else if (wr_cnt_lo)
      begin
        cycle_count_r[7:0] <= reg_wdata;
      end
      else if (wr_cnt_hi)
      begin
        cycle_count_r[15:8] <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_addr == `SCTC_OFS_CFG_A)
    begin
      reg_rdata <= cfg_a_r;
    end
    else if (reg_addr == `SCTC_OFS_CFG_B)
    begin
      reg_rdata <= cfg_b_r;
    end
    else if (reg_addr == `SCTC_OFS_CMD)
    begin
      reg_rdata <= {done_irq_enable_r, cycle_count_r[17:16], auto_scale_shift_r,
        repeat_count_r, done_flag_r, busy}; // RL15 RL17
    end
    else if (reg_addr == `SCTC_OFS_CNT_LO)
    begin
      reg_rdata <= cycle_count_r[7:0]; // RL17
    end
    else if (reg_addr == `SCTC_OFS_CNT_HI)
    begin
      reg_rdata <= cycle_count_r[15:8];
    end
    else if (reg_addr == `SCTC_OFS_IRQ_STAT)
    begin
      reg_rdata <= {6'h00, irq_stat_r};
    end
    else if (reg_addr == `SCTC_OFS_IRQ_MASK)
    begin
      reg_rdata <= {6'h00, irq_mask_r};
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // Timing runs entirely on sys_clk, the oscillator or its divided form. RL14

endmodule // sctc_touch_counter

// file: sctc_regs.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  switched-capacitance touch counter.
  Assumes an 8-bit register port addressed by the full 16-bit offset.
*/
`ifndef SCTC_REGS_VH
`define SCTC_REGS_VH

// Register offsets.
`define SCTC_OFS_CFG_A 16'ha008
`define SCTC_OFS_CFG_B 16'ha009
`define SCTC_OFS_CMD 16'ha00a
`define SCTC_OFS_CNT_LO 16'ha00b
`define SCTC_OFS_CNT_HI 16'ha00c
// Interrupt status and mask, placed just above the documented map.
`define SCTC_OFS_IRQ_STAT 16'ha00d
`define SCTC_OFS_IRQ_MASK 16'ha00e

// Reset value shared by every register.
`define SCTC_RST_BYTE 8'h00

// Configuration A fields.
`define SCTC_A_ENABLE 7
`define SCTC_A_RANDOM 6
`define SCTC_A_REFERENCE_SELECT 5
`define SCTC_A_THSEL 4
// Configuration B fields.
`define SCTC_B_PADEN 7
// Command register fields.
`define SCTC_C_IRQEN 7
`define SCTC_C_AUTO_SCALE_SHIFT 4
`define SCTC_C_DONE 1
`define SCTC_C_BUSY 0

// Zeroing time of the integration capacitor, in clock cycles.
`define SCTC_ZERO_BASE 12'd4
`define SCTC_ZERO_STEP 12'd128
`define SCTC_ZERO_TAIL 12'd2
`endif

// file: sctc_afe_model.sv
/*
  Behavioural analog front end: integration cap level as a count of dumps,
  followed by the testbench top that drives the register port.
  Assumes switch controls change just after rising edges of sys_clk.
*/
`include "sctc_regs.vh"
`timescale 1ns/100ps

module sctc_afe_model
#(
  // Dumps that lift the cap past each threshold.
  parameter integer DUMPS_3Q = 6,
  parameter integer DUMPS_HALF = 4
)
(
  // Clock.
  input wire sys_clk,
  // Switch controls and threshold select.
  input wire zero_sw,
  input wire dump_sw,
  input wire threshold_half,
  // Comparator.
  output wire comp_out
);
  // Dumps since the last zeroing, and the previous dump switch state.
  integer dumps = 0;
  reg dump_d = 1'b0;

  // The cap only ever gains charge, so the comparator never falls within a conversion.
  always @(posedge sys_clk)
  begin
    dump_d <= dump_sw;
    if (zero_sw)
      dumps <= 0;
    else if (dump_sw && !dump_d)
      dumps <= dumps + 1;
  end

  // A lower threshold is reached after fewer dumps.
  assign comp_out = dumps >= (threshold_half ? DUMPS_HALF : DUMPS_3Q);
endmodule // sctc_afe_model

module sctc_touch_counter_tb_top;
  // Clock, reset and register port drive.
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  // Design outputs.
  wire [7:0] reg_rdata;
  wire comp_out, zero_sw, charge_sw, dump_sw, threshold_half, reference_main;
  wire converter_enable, pad_drive_enable, irq;
  // Bookkeeping.
  integer miscompares = 0;
  integer comparisons = 0;
  integer polls;
  reg [7:0] rd_val;
  reg [7:0] cnt_lo;
  reg [7:0] cnt_hi;

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  sctc_touch_counter dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comp_out(comp_out), .zero_sw(zero_sw), .charge_sw(charge_sw), .dump_sw(dump_sw),
    .threshold_half(threshold_half), .reference_main(reference_main),
    .converter_enable(converter_enable), .pad_drive_enable(pad_drive_enable), .irq(irq));

  // Six dumps reach three quarters, four reach one half.
  sctc_afe_model #(.DUMPS_3Q(6), .DUMPS_HALF(4)) u_afe (.sys_clk(sys_clk), .zero_sw(zero_sw),
    .dump_sw(dump_sw), .threshold_half(threshold_half), .comp_out(comp_out));

  // One-cycle write strobe.
  task reg_write;
    input [15:0] addr;
    input [7:0] data;
    begin
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // One-cycle read strobe; data are taken mid-cycle while they stand.
  task reg_read;
    input [15:0] addr;
    output [7:0] data;
    begin
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      data = reg_rdata;
    end
  endtask

  // Compare and count.
  task check_val;
    input [8*8-1:0] what;
    input [17:0] seen;
    input [17:0] exp;
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // The single place that ends the run.
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Poll busy with a bound; running out counts as a mismatch.
  task wait_idle;
    begin
      polls = 0;
      rd_val = 8'h01;
      while (rd_val[0] && polls < 2000)
      begin
        reg_read(`SCTC_OFS_CMD, rd_val);
        polls = polls + 1;
      end
      if (rd_val[0])
      begin
        miscompares = miscompares + 1;
        $display("wait for idle ran out");
        tally_and_finish;
      end
    end
  endtask

  // One complete sequence with its expected count.
  task run_conv;
    input [1:0] repeat_count;
    input ash;
    input [17:0] exp;
    begin
      reg_write(`SCTC_OFS_CMD, {1'b1, 2'b00, ash, repeat_count, 2'b01});
      reg_read(`SCTC_OFS_CMD, rd_val);
      check_val("busy", {17'h00000, rd_val[0]}, 18'h00001);
      reg_read(`SCTC_OFS_CNT_LO, rd_val);
      check_val("cnt_clr", {10'h000, rd_val}, 18'h00000);
      wait_idle;
      reg_read(`SCTC_OFS_CNT_LO, cnt_lo);
      reg_read(`SCTC_OFS_CNT_HI, cnt_hi);
      reg_read(`SCTC_OFS_CMD, rd_val);
      check_val("count", {rd_val[6:5], cnt_hi, cnt_lo}, exp);
      check_val("done", {17'h00000, rd_val[1]}, 18'h00001);
      check_val("irq_on", {17'h00000, irq}, 18'h00001);
      reg_read(`SCTC_OFS_IRQ_STAT, rd_val);
      check_val("stat", {10'h000, rd_val}, 18'h00001);
      reg_read(`SCTC_OFS_IRQ_STAT, rd_val);
      check_val("stat_clr", {10'h000, rd_val}, 18'h00000);
      reg_write(`SCTC_OFS_CMD, {1'b1, 2'b00, ash, repeat_count, 2'b00});
      @(negedge sys_clk);
      check_val("irq_off", {17'h00000, irq}, 18'h00000);
      $display("conversion test finished");
    end
  endtask

  // Test sequence.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_read(`SCTC_OFS_CMD, rd_val);
    check_val("cmd_rst", {10'h000, rd_val}, 18'h00000);
    reg_write(`SCTC_OFS_CFG_A, 8'h87);
    reg_write(`SCTC_OFS_CFG_B, 8'h81);
    reg_read(`SCTC_OFS_CFG_A, rd_val);
    check_val("cfg_a", {10'h000, rd_val}, 18'h00087);
    check_val("thr", {17'h00000, threshold_half}, 18'h00000);
    check_val("ref", {17'h00000, reference_main}, 18'h00000);
    check_val("enable", {17'h00000, converter_enable}, 18'h00001);
    check_val("pad", {17'h00000, pad_drive_enable}, 18'h00001);
    reg_write(`SCTC_OFS_CNT_LO, 8'h5a);
    reg_read(`SCTC_OFS_CNT_LO, rd_val);
    check_val("cnt_wr", {10'h000, rd_val}, 18'h0005a);
    $display("register test finished");
    run_conv(2'd0, 1'b0, 18'd6);
    run_conv(2'd3, 1'b0, 18'd48);
    run_conv(2'd3, 1'b1, 18'd6);
    reg_write(`SCTC_OFS_CFG_A, 8'hb7);
    @(negedge sys_clk);
    check_val("thr_half", {17'h00000, threshold_half}, 18'h00001);
    check_val("ref_main", {17'h00000, reference_main}, 18'h00001);
    run_conv(2'd1, 1'b0, 18'd8);
    // Reset in the middle of zeroing.
    reg_write(`SCTC_OFS_CMD, 8'h81);
    repeat (50) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_read(`SCTC_OFS_CMD, rd_val);
    check_val("cmd_rst2", {10'h000, rd_val}, 18'h00000);
    reg_read(`SCTC_OFS_CFG_A, rd_val);
    check_val("cfg_rst2", {10'h000, rd_val}, 18'h00000);
    $display("reset test finished");
    reg_write(`SCTC_OFS_CFG_A, 8'h87);
    run_conv(2'd0, 1'b0, 18'd6);
    tally_and_finish;
  end
endmodule // sctc_touch_counter_tb_top

// file: sctc_touch_counter_chk.sv
/*
  Port assertions of the touch counter.
  Assumes timing fields are not rewritten while a conversion runs.
*/
`timescale 1ns/100ps
`include "sctc_regs.vh"

module sctc_touch_counter_chk
(
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register port.
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Switches, selects and interrupt.
  input wire zero_sw,
  input wire charge_sw,
  input wire dump_sw,
  input wire threshold_half,
  input wire reference_main,
  input wire converter_enable,
  input wire irq
);
  // Shadowed timing fields and interrupt gates.
  reg [3:0] base_r;
  reg [2:0] zero_r;
  reg irqen_r;
  reg [1:0] mask_r;
  // Run lengths of the switch phases.
  reg [10:0] zlen_r;
  reg [4:0] clen_r;
  reg [4:0] dlen_r;

  // Shadow writes and count phase lengths.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      base_r <= 4'h0;
      zero_r <= 3'h0;
      irqen_r <= 1'b0;
      mask_r <= 2'h0;
      zlen_r <= 11'h000;
      clen_r <= 5'h00;
      dlen_r <= 5'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `SCTC_OFS_CFG_A)
        base_r <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `SCTC_OFS_CFG_B)
        zero_r <= reg_wdata[6:4];
      if (reg_wr && reg_addr == `SCTC_OFS_CMD)
        irqen_r <= reg_wdata[7];
      if (reg_wr && reg_addr == `SCTC_OFS_IRQ_MASK)
        mask_r <= reg_wdata[1:0];
      zlen_r <= zero_sw ? zlen_r + 11'h001 : 11'h000;
      clen_r <= charge_sw ? clen_r + 5'h01 : 5'h00;
      dlen_r <= dump_sw ? dlen_r + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sw_exclusive_a: assert property ($onehot0({zero_sw, charge_sw, dump_sw}))
    else $error("switches overlap");
  zero_len_a: assert property ($fell(zero_sw) |-> zlen_r == 11'd135 + {1'b0, zero_r, 7'h00})
    else $error("zeroing length wrong");
  charge_len_a: assert property ($fell(charge_sw) |-> clen_r == {1'b0, base_r} + 5'h01)
    else $error("charge length wrong");
  dump_len_a: assert property ($fell(dump_sw) |-> dlen_r == {1'b0, base_r} + 5'h01)
    else $error("dump length wrong");
  irq_quiet_a: assert property ((!irqen_r && mask_r == 2'b00) |-> !irq)
    else $error("interrupt without enable");
  rdata_idle_a: assert property ($past(!reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  thresh_route_a: assert property ($past(reg_wr && reg_addr == `SCTC_OFS_CFG_A)
    |-> threshold_half == $past(reg_wdata[4])) else $error("threshold select not routed");
  ref_route_a: assert property ($past(reg_wr && reg_addr == `SCTC_OFS_CFG_A)
    |-> reference_main == $past(reg_wdata[5])) else $error("reference select not routed");
endmodule // sctc_touch_counter_chk

bind sctc_touch_counter sctc_touch_counter_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .zero_sw, .charge_sw, .dump_sw, .threshold_half,
  .reference_main, .converter_enable, .irq);
